// file: rtl/dos_pkg.sv
// package: register map, field layout and constants of the offset/shift-pulse bank
package dos_pkg;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_LINE1_OFFSET = 5'h0f;
    localparam logic [4:0] IDX_LINE2_OFFSET = 5'h10;
    localparam logic [4:0] IDX_LINE3_OFFSET = 5'h11;
    localparam logic [4:0] IDX_LINE4_OFFSET = 5'h12;
    localparam logic [4:0] IDX_LINE5_OFFSET = 5'h13;
    localparam logic [4:0] IDX_PAGE_SELECT = 5'h1f;
    localparam logic [4:0] IDX_STATUS = 5'h1e;
    localparam logic [4:0] IDX_SHIFT_CTRL = 5'h00;
    localparam logic [4:0] IDX_SHIFT_WIDTH = 5'h01;
    localparam logic [4:0] IDX_SHIFT_PERIOD = 5'h04;
    // pages
    localparam logic [7:0] PAGE_OFFSETS = 8'h01;
    localparam logic [7:0] PAGE_TIMING = 8'h02;
    // reset values
    localparam logic [6:0] OFFSET_RESET = 7'h40;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] SHIFT_CTRL_RESET = 8'h00;
    localparam logic [7:0] SHIFT_WIDTH_RESET = 8'h27;
    localparam logic [7:0] SHIFT_PERIOD_RESET = 8'hff;
    // shift-pulse control fields
    localparam int unsigned SP_TRISTATE_BIT = 7;
    localparam int unsigned SP_MASTER_BIT = 6;
    localparam int unsigned SP_MODE_HI = 5;
    localparam int unsigned SP_MODE_LO = 4;
    localparam logic [1:0] SP_MODE_LOW = 2'h2;
    localparam logic [1:0] SP_MODE_HIGH = 2'h3;
    // widths and counts
    localparam int unsigned NUM_LINES = 5;
    localparam int unsigned OFFSET_W = 7;
    localparam int unsigned ADC_W = 16;
    localparam int unsigned PERIOD_UNIT = 16;
    // shift-pulse generator states
    typedef enum logic [0:0] {SPG_IDLE, SPG_PULSE} dos_spg_state_t;
endpackage

// file: rtl/dos_cfg_if.sv
// interface: configuration and status between register bank and its users
`timescale 1ns/100ps
interface dos_cfg_if;
    logic [4:0][6:0] line_offset; // per-line / per-input offsets
    logic [7:0] shift_ctrl; // shift-pulse control
    logic [7:0] shift_width; // pulse width code
    logic [7:0] shift_period; // master period code
    logic gate_level; // pin level driven
    logic gate_busy; // pulse in progress
    modport regs (output line_offset, shift_ctrl, shift_width, shift_period,
        input gate_level, gate_busy);
    modport offset_user (input line_offset);
    modport pulse_user (input shift_ctrl, shift_width, shift_period,
        output gate_level, gate_busy);
endinterface

// file: rtl/dos_offset_adder.sv
// module: adds the selected digital offset to the converter result
`timescale 1ns/100ps
module dos_offset_adder
    import dos_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    dos_cfg_if.offset_user cfg,
    // converter side
    input wire logic adc_valid,
    input wire logic [15:0] adc_result,
    input wire logic line_multiplexed_mode,
    input wire logic [2:0] line_colour,
    input wire logic [1:0] input_channel,
    output logic [15:0] corrected,
    output logic corrected_valid
);
    // registered state
    typedef struct packed {
        logic [15:0] data;
        logic valid;
    } dos_add_state_t;
    dos_add_state_t st_q, st_d;
    logic [6:0] sel;
    logic signed [17:0] sum;

    // pick offset, remove the binary bias, saturate
    always_comb begin
        st_d = st_q;
        sel = OFFSET_RESET; // bias value means no offset
        if (line_multiplexed_mode) begin
            if (line_colour < 3'(NUM_LINES)) begin
                sel = cfg.line_offset[line_colour];
            end
        end else if (input_channel != 2'h3) begin
            sel = cfg.line_offset[input_channel];
        end
        sum = $signed({2'h0, adc_result}) + $signed({11'h0, sel})
            - $signed({11'h0, OFFSET_RESET});
        st_d.valid = adc_valid;
        if (adc_valid) begin
            if (sum < 0) begin
                st_d.data = 16'h0000;
            end else if (sum > 18'sh0ffff) begin
                st_d.data = 16'hffff;
            end else begin
                st_d.data = sum[15:0];
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign corrected = st_q.data;
    assign corrected_valid = st_q.valid;
endmodule

// file: rtl/dos_shift_pulse_gen.sv
// module: transfer gate pulse generator, slave or master timing
`timescale 1ns/100ps
module dos_shift_pulse_gen
    import dos_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    dos_cfg_if.pulse_user cfg,
    // sensor side
    input wire logic transfer_request_input,
    output logic transfer_gate_pulse_o,
    output logic transfer_gate_pulse_oe
);
    // registered state
    typedef struct packed {
        dos_spg_state_t st;
        logic [8:0] width_cnt;
        logic [11:0] period_cnt;
        logic req_q;
        logic pin;
        logic oe;
    } dos_spg_reg_t;
    dos_spg_reg_t r_q, r_d;
    logic start;
    logic [1:0] mode;

    // start, count and shape the pulse
    always_comb begin
        r_d = r_q;
        r_d.req_q = transfer_request_input;
        start = 1'b0;
        if (cfg.shift_ctrl[SP_MASTER_BIT]) begin
            // master: free period counter
            if (r_q.period_cnt == 12'h000) begin
                r_d.period_cnt = 12'(({4'h0, cfg.shift_period} + 12'h001) * PERIOD_UNIT - 1);
                start = 1'b1;
            end else begin
                r_d.period_cnt = r_q.period_cnt - 12'h001;
            end
        end else begin
            // slave: rising edge of the request
            r_d.period_cnt = 12'h000;
            start = transfer_request_input && !r_q.req_q;
        end
        unique case (r_q.st)
            SPG_IDLE: begin
                if (start) begin
                    r_d.st = SPG_PULSE;
                    r_d.width_cnt = {cfg.shift_width, 1'b0}; // 2*w+1 cycles
                end
            end
            SPG_PULSE: begin
                if (r_q.width_cnt == 9'h000) begin
                    r_d.st = SPG_IDLE;
                end else begin
                    r_d.width_cnt = r_q.width_cnt - 9'h001;
                end
            end
        endcase
        mode = cfg.shift_ctrl[SP_MODE_HI:SP_MODE_LO];
        if (mode == SP_MODE_LOW) begin
            r_d.pin = 1'b0;
        end else if (mode == SP_MODE_HIGH) begin
            r_d.pin = 1'b1;
        end else begin
            r_d.pin = (r_d.st == SPG_PULSE);
        end
        r_d.oe = !cfg.shift_ctrl[SP_TRISTATE_BIT];
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign transfer_gate_pulse_o = r_q.pin;
    assign transfer_gate_pulse_oe = r_q.oe;
    assign cfg.gate_level = r_q.pin;
    assign cfg.gate_busy = (r_q.st == SPG_PULSE);
endmodule

// file: rtl/dos_top.sv
// top: APB register bank for digital offsets and transfer gate pulse control
// Function
// - line-multiplexed mode adds offset of current line
// - other modes: offsets one-three serve red/green/blue
// - offsets four and five ignored outside line-multiplexed
// - offsets are offset binary, reset means zero
// - accesses routed by page select, resets zero
// - tristate bit one floats pulse, zero drives
// - source bit zero: pulse started by request
// - source bit one: internal period and width
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module dos_top
    import dos_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter data path
    input wire logic adc_valid,
    input wire logic [15:0] adc_result,
    input wire logic line_multiplexed_mode,
    input wire logic [2:0] line_colour,
    input wire logic [1:0] input_channel,
    output logic [15:0] corrected,
    output logic corrected_valid,
    // sensor timing
    input wire logic transfer_request_input,
    output logic transfer_gate_pulse_o,
    output logic transfer_gate_pulse_oe
);
    import dos_pkg::*;

    // register identities after page decode
    typedef enum logic [3:0] {
        RID_NONE, RID_LINE1, RID_LINE2, RID_LINE3, RID_LINE4, RID_LINE5,
        RID_PAGE, RID_STATUS, RID_SHIFT_CTRL, RID_SHIFT_WIDTH, RID_SHIFT_PERIOD
    } dos_rid_t;

    // all register state of the bank
    typedef struct packed {
        logic [7:0] page; // page select
        logic [4:0][6:0] line_offset; // five offset registers
        logic [7:0] shift_ctrl; // shift-pulse control
        logic [7:0] shift_width; // pulse width code
        logic [7:0] shift_period; // master period code
        logic [7:0] rdata; // captured read data
        logic err; // captured error answer
    } dos_bank_t;

    dos_bank_t b_q, b_d;
    dos_rid_t rid; // decoded target of current access
    logic setup_phase; // first cycle of a transfer
    logic write_done; // access phase of a write
    logic [7:0] wbyte; // low write byte

    // configuration carrier to the users
    dos_cfg_if cfg ();

    // decode address and current page into a register identity
    function automatic dos_rid_t decode(input logic [7:0] addr, input logic [7:0] page);
        dos_rid_t id;
        id = RID_NONE;
        // misaligned addresses hit nothing
        if (addr[1:0] == 2'h0) begin
            // upper half of the map is never decoded
            if (addr[7]) begin
                id = RID_NONE;
            // page select and status are reachable on every page
            end else if (addr[6:2] == IDX_PAGE_SELECT) begin
                id = RID_PAGE;
            end else if (addr[6:2] == IDX_STATUS) begin
                id = RID_STATUS;
            end else if (page == PAGE_OFFSETS) begin
                // offset page
                unique case (addr[6:2])
                    IDX_LINE1_OFFSET: id = RID_LINE1;
                    IDX_LINE2_OFFSET: id = RID_LINE2;
                    IDX_LINE3_OFFSET: id = RID_LINE3;
                    IDX_LINE4_OFFSET: id = RID_LINE4;
                    IDX_LINE5_OFFSET: id = RID_LINE5;
                    default: id = RID_NONE;
                endcase
            end else if (page == PAGE_TIMING) begin
                // timing generator page
                unique case (addr[6:2])
                    IDX_SHIFT_CTRL: id = RID_SHIFT_CTRL;
                    IDX_SHIFT_WIDTH: id = RID_SHIFT_WIDTH;
                    IDX_SHIFT_PERIOD: id = RID_SHIFT_PERIOD;
                    default: id = RID_NONE;
                endcase
            end
        end
        return id;
    endfunction

    // index of an offset register within the line array
    function automatic logic [2:0] line_index(input dos_rid_t id);
        logic [2:0] idx;
        idx = 3'h0;
        unique case (id)
            RID_LINE2: idx = 3'h1;
            RID_LINE3: idx = 3'h2;
            RID_LINE4: idx = 3'h3;
            RID_LINE5: idx = 3'h4;
            default: idx = 3'h0;
        endcase
        return idx;
    endfunction

    // decode with the page register as it stands now
    assign rid = decode(paddr, b_q.page);
    assign setup_phase = psel && !penable;
    assign write_done = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];

    // next-state logic of the bank
    always_comb begin
        b_d = b_q;
        // read data and error are captured in the setup cycle
        if (setup_phase) begin
            b_d.err = (rid == RID_NONE);
            b_d.rdata = 8'h00;
            if (!pwrite) begin
                unique case (rid)
                    RID_LINE1, RID_LINE2, RID_LINE3, RID_LINE4, RID_LINE5: begin
                        // unused top bit reads zero
                        b_d.rdata = {1'b0, b_q.line_offset[line_index(rid)]};
                    end
                    RID_PAGE: begin
                        b_d.rdata = b_q.page;
                    end
                    RID_STATUS: begin
                        // live generator state
                        b_d.rdata = {6'h00, cfg.gate_busy, cfg.gate_level};
                    end
                    RID_SHIFT_CTRL: begin
                        b_d.rdata = b_q.shift_ctrl;
                    end
                    RID_SHIFT_WIDTH: begin
                        b_d.rdata = b_q.shift_width;
                    end
                    RID_SHIFT_PERIOD: begin
                        b_d.rdata = b_q.shift_period;
                    end
                    default: begin
                        b_d.rdata = 8'h00;
                    end
                endcase
            end
        end
        // writes land in the access phase, zero wait states
        if (write_done && !b_q.err) begin
            unique case (rid)
                RID_LINE1, RID_LINE2, RID_LINE3, RID_LINE4, RID_LINE5: begin
                    // top bit is not stored
                    b_d.line_offset[line_index(rid)] = wbyte[6:0];
                end
                RID_PAGE: begin
                    // new page applies to the next access
                    b_d.page = wbyte;
                end
                RID_SHIFT_CTRL: begin
                    b_d.shift_ctrl = wbyte;
                end
                RID_SHIFT_WIDTH: begin
                    b_d.shift_width = wbyte;
                end
                RID_SHIFT_PERIOD: begin
                    b_d.shift_period = wbyte;
                end
                default: begin
                    // status and unmapped: nothing stored
                end
            endcase
        end
    end

    // bank register, reset to documented defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_q.page <= PAGE_RESET;
            b_q.line_offset <= {NUM_LINES{OFFSET_RESET}};
            b_q.shift_ctrl <= SHIFT_CTRL_RESET;
            b_q.shift_width <= SHIFT_WIDTH_RESET;
            b_q.shift_period <= SHIFT_PERIOD_RESET;
            b_q.rdata <= 8'h00;
            b_q.err <= 1'b0;
        end else begin
            b_q <= b_d;
        end
    end

    // apb answer: always ready, error on unmapped
    assign pready = 1'b1;
    assign prdata = {24'h000000, b_q.rdata};
    assign pslverr = psel && penable && b_q.err;

    // configuration out to the users
    assign cfg.line_offset = b_q.line_offset;
    assign cfg.shift_ctrl = b_q.shift_ctrl;
    assign cfg.shift_width = b_q.shift_width;
    assign cfg.shift_period = b_q.shift_period;

    // offset adder on the converter result
    dos_offset_adder u_adder (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.offset_user),
        .adc_valid(adc_valid),
        .adc_result(adc_result),
        .line_multiplexed_mode(line_multiplexed_mode),
        .line_colour(line_colour),
        .input_channel(input_channel),
        .corrected(corrected),
        .corrected_valid(corrected_valid)
    );

    // transfer gate pulse generator
    dos_shift_pulse_gen u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.pulse_user),
        .transfer_request_input(transfer_request_input),
        .transfer_gate_pulse_o(transfer_gate_pulse_o),
        .transfer_gate_pulse_oe(transfer_gate_pulse_oe)
    );
endmodule

// file: verification/dos_sensor_model.sv
// sensor model: request source and gate pin observer
`timescale 1ns/100ps
module dos_sensor_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench command
    input wire logic fire,
    // gate pin halves from the block
    input wire logic gate_o,
    input wire logic gate_oe,
    // request and observations
    output logic req,
    output logic pin,
    output logic [8:0] last_len,
    output logic [7:0] rises
);
    logic [8:0] run_q; // high cycles so far
    logic [1:0] hold_q; // request cycles left
    // floating pin pulled low in the sensor
    assign pin = gate_oe ? gate_o : 1'b0;
    // request held two cycles per command
    assign req = hold_q != 2'h0;
    // pulse length and edge counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 2'h0;
            run_q <= 9'h000;
            last_len <= 9'h000;
            rises <= 8'h00;
        end else begin
            hold_q <= fire ? 2'h2 : (req ? hold_q - 2'h1 : 2'h0);
            run_q <= pin ? run_q + 9'h001 : 9'h000;
            if (!pin && run_q != 9'h000) begin
                last_len <= run_q;
            end
            if (pin && run_q == 9'h000) begin
                rises <= rises + 8'h01;
            end
        end
    end
endmodule

// file: verification/dos_top_monitor.sv
// checker: port-level properties of the offset and pulse bank
`timescale 1ns/100ps
module dos_top_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter
    input wire logic adc_valid,
    input wire logic corrected_valid,
    // sensor
    input wire logic transfer_request_input,
    input wire logic transfer_gate_pulse_o,
    input wire logic transfer_gate_pulse_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] page_q; // shadow of page select
    logic [7:0] ctrl_q; // shadow of pulse control
    logic [7:0] width_q; // shadow of pulse width
    logic [8:0] hi_q; // high-level run length
    logic wr; // committed write
    assign wr = psel && penable && pready && pwrite && !pslverr;
    // shadows follow committed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= 8'h00;
            ctrl_q <= 8'h00;
            width_q <= 8'h27;
            hi_q <= 9'h000;
        end else begin
            hi_q <= transfer_gate_pulse_o ? hi_q + 9'h001 : 9'h000;
            if (wr && paddr == 8'h7c) begin
                page_q <= pwdata[7:0];
            end
            if (wr && page_q == 8'h02 && paddr == 8'h00) begin
                ctrl_q <= pwdata[7:0];
            end
            if (wr && page_q == 8'h02 && paddr == 8'h04) begin
                width_q <= pwdata[7:0];
            end
        end
    end
    sequence s_settled;
        $past(presetn) && $stable(ctrl_q);
    endsequence
    sequence s_trig;
        s_settled ##0 ctrl_q[6:5] == 2'b00 && $rose(transfer_request_input)
            && !transfer_gate_pulse_o && !$past(transfer_gate_pulse_o);
    endsequence
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_bad_addr_err: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr[7])
        |-> pslverr) else $error("bad address not refused");
    a_read_clean: assert property (psel && penable && !pwrite
        |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
        else $error("read data upper bits set");
    a_sample_result: assert property (adc_valid |=> corrected_valid)
        else $error("result missing");
    a_no_stray: assert property (!adc_valid |=> !corrected_valid)
        else $error("stray result");
    a_oe_from_ctrl: assert property (s_settled |-> transfer_gate_pulse_oe == !ctrl_q[7])
        else $error("output enable wrong");
    a_forced_level: assert property (s_settled ##0 ctrl_q[5]
        |-> transfer_gate_pulse_o == ctrl_q[4]) else $error("forced level wrong");
    a_slave_start: assert property (s_trig |=> transfer_gate_pulse_o)
        else $error("pulse not started");
    a_pulse_len: assert property ($fell(transfer_gate_pulse_o) ##0 s_settled ##0 !ctrl_q[5]
        |-> hi_q == {width_q, 1'b1}) else $error("pulse width wrong");
endmodule

// file: verification/tb.sv
// testbench: registers, offset path and transfer gate pulse
`timescale 1ns/100ps
module tb;
    import dos_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, adc_valid = 1'b0, line_multiplexed_mode = 1'b0, fire = 1'b0;
    logic [15:0] adc_result = 16'h0, corrected;
    logic [2:0] line_colour = 3'h0;
    logic [1:0] input_channel = 2'h0;
    logic corrected_valid, req, gate_o, gate_oe, pin;
    logic [8:0] last_len;
    logic [7:0] rises;
    logic [7:0] offs [5] = '{8'h41, 8'h3e, 8'h50, 8'h00, 8'h7f}; // line offsets
    int err_total = 0, checks = 0;
    // device and sensor
    dos_top u_dos_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_valid(adc_valid), .adc_result(adc_result),
        .line_multiplexed_mode(line_multiplexed_mode), .line_colour(line_colour),
        .input_channel(input_channel), .corrected(corrected),
        .corrected_valid(corrected_valid), .transfer_request_input(req),
        .transfer_gate_pulse_o(gate_o), .transfer_gate_pulse_oe(gate_oe));
    dos_sensor_model u_dos_sensor_model (.pclk(pclk), .presetn(presetn), .fire(fire),
        .gate_o(gate_o), .gate_oe(gate_oe), .req(req), .pin(pin), .last_len(last_len),
        .rises(rises));
    // clock
    always #2.5 pclk = ~pclk;
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic finish_test;
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check("read data", r, exp);
        check("read error", {31'h0, e}, {31'h0, experr});
    endtask
    // one converter sample and its result
    task automatic send(input logic lm, input logic [2:0] c, input logic [1:0] ch,
        input logic [15:0] d, input logic [15:0] exp);
        @(posedge pclk);
        adc_valid <= 1'b1;
        line_multiplexed_mode <= lm;
        line_colour <= c;
        input_channel <= ch;
        adc_result <= d;
        @(posedge pclk);
        adc_valid <= 1'b0;
        #1 check("result valid", {31'h0, corrected_valid}, 32'h1);
        check("corrected", {16'h0, corrected}, {16'h0, exp});
    endtask
    // reset values, unused bit, refusals
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd(8'h7c, 32'h0, 1'b0);
        wr(8'h7c, PAGE_OFFSETS);
        for (int k = 0; k < 5; k++) rd(8'h3c + 8'(4 * k), 32'h40, 1'b0);
        wr(8'h3c, 8'hff);
        rd(8'h3c, 32'h7f, 1'b0);
        apb(1'b1, 8'h00, 8'h80, r, e);
        check("wrong page write", {31'h0, e}, 32'h1);
        rd(8'h08, 32'h0, 1'b1);
        rd(8'h3d, 32'h0, 1'b1);
        wr(8'h7c, PAGE_TIMING);
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h04, 32'h27, 1'b0);
    endtask
    // offsets per line, then per input
    task automatic t_offsets;
        wr(8'h7c, PAGE_OFFSETS);
        for (int k = 0; k < 5; k++) wr(8'h3c + 8'(4 * k), offs[k]);
        for (int k = 0; k < 5; k++) send(1'b1, 3'(k), 2'h3, 16'h1000,
            16'h1000 + {9'h0, offs[k][6:0]} - 16'h40);
        send(1'b1, 3'h3, 2'h0, 16'h0010, 16'h0000);
        for (int k = 0; k < 3; k++) send(1'b0, 3'h4, 2'(k), 16'h2000,
            16'h2000 + {9'h0, offs[k][6:0]} - 16'h40);
        send(1'b0, 3'h3, 2'h3, 16'h2000, 16'h2000);
    endtask
    // slave pulse, forced levels, tristate, master period
    task automatic t_pulse;
        logic [7:0] r0;
        int n;
        wr(8'h7c, PAGE_TIMING);
        wr(8'h04, 8'h02);
        fire <= 1'b1;
        @(posedge pclk) fire <= 1'b0;
        repeat (12) @(posedge pclk);
        check("slave pulse", {24'h0, rises}, 32'h1);
        check("slave width", {23'h0, last_len}, 32'h5);
        wr(8'h00, 8'h20);
        fire <= 1'b1;
        @(posedge pclk) fire <= 1'b0;
        repeat (8) @(posedge pclk);
        check("forced low", {24'h0, rises}, 32'h1);
        wr(8'h00, 8'h30);
        repeat (3) @(posedge pclk);
        check("forced high", {31'h0, pin}, 32'h1);
        wr(8'h00, 8'ha0);
        repeat (3) @(posedge pclk);
        check("tristate", {31'h0, gate_oe}, 32'h0);
        wr(8'h00, 8'h10);
        repeat (3) @(posedge pclk);
        check("driven", {31'h0, gate_oe}, 32'h1);
        r0 = rises;
        fire <= 1'b1;
        @(posedge pclk) fire <= 1'b0;
        repeat (12) @(posedge pclk);
        check("mode one pass", {24'h0, rises}, {24'h0, r0 + 8'h01});
        wr(8'h10, 8'h00);
        wr(8'h00, 8'h40);
        for (int p = 0; p < 2; p++) begin
            r0 = rises;
            n = 0;
            while (rises == r0 && n < 100) begin
                @(posedge pclk);
                #1;
                n++;
            end
        end
        check("master period", n, 32'd16);
        check("master width", {23'h0, last_len}, 32'h5);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_offsets();
        t_pulse();
        finish_test();
    end
endmodule
bind dos_top dos_top_monitor u_dos_top_monitor (.*);
